// [verification/reset_and_power_mode_control_tb.sv]
module reset_and_power_mode_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 0, rst = 1, low_voltage_reset = 0, press = 0;
  logic watchdog_timeout = 0, xtal_mode = 0, startup_fast = 1;
  logic halt_instruction = 0, watchdog_clear_instruction = 0;
  logic mode_write = 0, fast_osc_select = 1, fast_osc_stop = 0;
  logic [1:0] operating_mode_field = 2'h0;
  logic [2:0] pwrup_delay_sel = 3'h4;
  logic timer0_enable = 1, timer1_enable = 1, periph_enable = 1;
  logic watchdog_option = 1, watchdog_enable = 1, timer0_overflow = 0;
  logic timer1_underflow = 0, input_change_port = 0, ext_interrupt = 0;
  logic low_voltage_detect = 0, ext_reset_pin_n, system_reset;
  logic timeout_flag_n, powerdown_flag_n, cpu_run, fast_osc_en;
  logic slow_osc_en, sys_clk_fast, timer0_run, timer1_run, periph_run;
  logic watchdog_run;
  int error_cnt = 0, num_checks = 0;
  reset_and_power_mode_control #(.PWRUP_DEF_CYC(200)) uut (.*);
  reset_pin_model pin_i (.ref_clk(ref_clk), .press(press),
    .ext_reset_pin_n(ext_reset_pin_n));
  initial forever #50 ref_clk = ~ref_clk;
  task chk(input logic [2:0] s, input logic [2:0] e);
    num_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task wait_run;
    for (int i = 0; i < 600 && cpu_run !== 1'b1; i++) tick(1);
    chk(cpu_run, 1);
  endtask
  task halt_now;
    halt_instruction = 1;
    tick(1);
    halt_instruction = 0;
    chk({timeout_flag_n, powerdown_flag_n}, 2'h2);
    chk({fast_osc_en, slow_osc_en, timer0_run}, 3'h0);
    chk({timer1_run, periph_run, watchdog_run}, 3'h1);
  endtask
  // One source at a time; flags follow the source and the mode.
  task src_reset(input int which, input logic [1:0] exp);
    if (which == 0) watchdog_timeout = 1;
    else if (which == 1) press = 1;
    else low_voltage_reset = 1;
    tick(6);
    chk(system_reset, 1);
    chk({timeout_flag_n, powerdown_flag_n}, exp);
    {watchdog_timeout, press, low_voltage_reset} = 3'h0;
    tick(5);
    chk(cpu_run, 0);
    wait_run();
  endtask
  task halt_wake;
    for (int x = 0; x < 2; x++) begin
      xtal_mode = x[0];
      fast_osc_select = !x[0];
      halt_now();
      tick(30);
      chk(cpu_run, 0);
      ext_interrupt = 1;
      tick(x == 0 ? 10 : 100);
      ext_interrupt = 0;
      chk(cpu_run, 0);
      wait_run();
      chk(sys_clk_fast, !x[0]);
    end
  endtask
  task standby;
    mode_write = 1;
    operating_mode_field = 2'h2;
    tick(1);
    mode_write = 0;
    chk({cpu_run, slow_osc_en}, 2'h1);
    timer0_overflow = 1;
    tick(1);
    timer0_overflow = 0;
    tick(8);
    chk(cpu_run, 1);
  endtask
  task report_and_stop;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    tick(10);
    chk({system_reset, timeout_flag_n, powerdown_flag_n}, 3'h7);
    rst = 0;
    wait_run();
    halt_wake();
    watchdog_clear_instruction = 1;
    tick(1);
    watchdog_clear_instruction = 0;
    chk({timeout_flag_n, powerdown_flag_n}, 2'h3);
    standby();
    src_reset(0, 2'h1);
    src_reset(1, 2'h1);
    src_reset(2, 2'h3);
    halt_now();
    src_reset(0, 2'h0);
    halt_now();
    src_reset(1, 2'h3);
    report_and_stop();
  end
  initial begin
    #4ms;
    error_cnt++;
    report_and_stop();
  end
endmodule // reset_and_power_mode_control_tb

// [verification/reset_pin_model.sv]
module reset_pin_model (
  // Clock and button.
  input wire logic ref_clk,
  input wire logic press,
  // Pin with pull-up.
  output logic ext_reset_pin_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // Released, the pull-up wins, so the pin never floats.
  always_ff @(posedge ref_clk) ext_reset_pin_n <= !press;
endmodule // reset_pin_model

// [verification/rst_pwr_checker.sv]
`include "rst_pwr_cfg.svh"
module rst_pwr_checker (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // Watched inputs.
  input wire logic low_voltage_reset,
  input wire logic ext_reset_pin_n,
  input wire logic halt_instruction,
  input wire logic watchdog_clear_instruction,
  input wire logic mode_write,
  input wire logic [1:0] operating_mode_field,
  // Watched outputs.
  input wire logic system_reset,
  input wire logic timeout_flag_n,
  input wire logic powerdown_flag_n,
  input wire logic cpu_run,
  input wire logic fast_osc_en,
  input wire logic slow_osc_en,
  input wire logic timer0_run
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_rst_flags: assert property (
    $fell(rst) |-> timeout_flag_n && powerdown_flag_n && system_reset)
    else $error("power-on flags wrong");
  a_halt_flags: assert property (
    halt_instruction && cpu_run |=> timeout_flag_n && !powerdown_flag_n)
    else $error("halt flags wrong");
  a_clear_flags: assert property (
    watchdog_clear_instruction && !halt_instruction && cpu_run
    |=> timeout_flag_n && powerdown_flag_n) else $error("clear flags wrong");
  a_lvr_hold: assert property (
    low_voltage_reset [*4] |-> system_reset && !cpu_run)
    else $error("low voltage did not hold reset");
  a_pin_hold: assert property (
    !ext_reset_pin_n [*4] |-> system_reset) else $error("pin ignored");
  a_seq_min: assert property (
    $rose(system_reset) |=> system_reset [*8])
    else $error("reset sequence too short");
  a_standby_go: assert property (
    mode_write && operating_mode_field == `OPMODE_STANDBY && cpu_run &&
    !halt_instruction |=> !cpu_run && slow_osc_en)
    else $error("standby entry wrong");
  a_halt_gate: assert property (
    (halt_instruction || mode_write && operating_mode_field == `OPMODE_HALT)
    && cpu_run |=> !cpu_run && !fast_osc_en && !slow_osc_en && !timer0_run)
    else $error("halt gating wrong");
endmodule // rst_pwr_checker
bind reset_and_power_mode_control rst_pwr_checker chk_i (.*);

// [verilog/reset_and_power_mode_control.sv]
`include "rst_pwr_cfg.svh"
// Notes on behaviour
// - Reset on power-up, low voltage, pin, watchdog.
// - Reset loads defined values, keeps undefined ones.
// - Power-on or low-voltage reset sets both flags.
// - Pin reset outside halt keeps both flags.
// - Pin reset during halt sets both flags.
// - Watchdog reset outside halt: timeout 0, powerdown 1.
// - Watchdog reset during halt clears both flags.
// - Halt instruction sets timeout, clears powerdown (a 01b write keeps both); clear sets both.
// - Sequence starts only after all sources release.
// - Wait selectable power-up delay after release.
// - Then count sixteen oscillator start-up cycles.
// - Standby stops execution, slow oscillator runs, wakes.
// - Halt gates everything but the watchdog; three wake sources only.
// - Halt by instruction or 01b; standby 10b.
// - Halt wake waits 512 or 16 cycles.
// - Wake resumes normal or slow per select bit.
module reset_and_power_mode_control
  import rst_pwr_pkg::*;
#(
  parameter int PWRUP_SEL_W = 3,
  parameter int PWRUP_DEF_CYC = `PWRUP_US_4 * `CLK_MHZ
) (
  // Clock and power-on detection (synchronous, active high).
  input wire logic ref_clk,
  input wire logic rst,
  // Asynchronous reset sources.
  input wire logic low_voltage_reset,
  input wire logic ext_reset_pin_n,
  input wire logic watchdog_timeout,
  // Configuration.
  input wire logic [PWRUP_SEL_W-1:0] pwrup_delay_sel,
  input wire logic xtal_mode,
  input wire logic startup_fast,
  // Core requests, same clock.
  input wire logic halt_instruction,
  input wire logic watchdog_clear_instruction,
  input wire logic mode_write,
  input wire logic [1:0] operating_mode_field,
  input wire logic fast_osc_select,
  input wire logic fast_osc_stop,
  input wire logic timer0_enable,
  input wire logic timer1_enable,
  input wire logic periph_enable,
  input wire logic watchdog_option,
  input wire logic watchdog_enable,
  // Wake-up events.
  input wire logic timer0_overflow,
  input wire logic timer1_underflow,
  input wire logic input_change_port,
  input wire logic ext_interrupt,
  input wire logic low_voltage_detect,
  // Reset and status outputs.
  output logic system_reset,
  output logic timeout_flag_n,
  output logic powerdown_flag_n,
  // Clock and module gating.
  output logic cpu_run,
  output logic fast_osc_en,
  output logic slow_osc_en,
  output logic sys_clk_fast,
  output logic timer0_run,
  output logic timer1_run,
  output logic periph_run,
  output logic watchdog_run
);
  localparam int CNT_W = 32;

  initial begin
    if (PWRUP_SEL_W < 3) $error("pwrup_delay_sel must hold five codes");
    if (PWRUP_DEF_CYC < 1) $error("power-up delay must be positive");
  end

  // Scale the printed delays by the longest one so PWRUP_DEF_CYC shortens
  // every selection proportionally in simulation.
  function automatic logic [CNT_W-1:0] pwrup_cycles(
    input logic [PWRUP_SEL_W-1:0] sel);
    longint us;
    longint c;
    us = `PWRUP_US_4;
    case (sel)
      0: us = `PWRUP_US_0;
      1: us = `PWRUP_US_1;
      2: us = `PWRUP_US_2;
      3: us = `PWRUP_US_3;
      default: us = `PWRUP_US_4;
    endcase
    c = (us * PWRUP_DEF_CYC + `PWRUP_US_4 - 1) / `PWRUP_US_4;
    if (c < 1) c = 1;
    return CNT_W'(c);
  endfunction

  logic lvr_s, pin_n_s, wdt_s, chg_s, int_s;
  sync2 #(.WIDTH(5)) u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .async_in({low_voltage_reset, ext_reset_pin_n, watchdog_timeout,
               input_change_port, ext_interrupt}),
    .reset_val(5'b0_1000),
    .sync_out({lvr_s, pin_n_s, wdt_s, chg_s, int_s})
  );

  seq_state_e state_r, state_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic to_r, to_nxt, pd_r, pd_nxt, fast_r, fast_nxt;
  logic src_active;
  logic in_halt;

  assign src_active = lvr_s | ~pin_n_s | wdt_s;
  assign in_halt = (state_r == ST_HALT) || (state_r == ST_WAKE);

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    to_nxt = to_r;
    pd_nxt = pd_r;
    fast_nxt = fast_r;
    if (rst || lvr_s) begin
      to_nxt = 1'b1;
      pd_nxt = 1'b1;
    end else if (wdt_s && state_r != ST_HOLD) begin
      // Only the first cycle of a watchdog reset sees the halt state.
      // Once the sequencer holds, the flags must keep that verdict.
      to_nxt = 1'b0;
      pd_nxt = in_halt ? 1'b0 : 1'b1;
    end else if (~pin_n_s && in_halt) begin
      to_nxt = 1'b1;
      pd_nxt = 1'b1;
    end else if (state_r == ST_RUN && halt_instruction) begin
      to_nxt = 1'b1;
      pd_nxt = 1'b0;
    end else if (state_r == ST_RUN && watchdog_clear_instruction) begin
      to_nxt = 1'b1;
      pd_nxt = 1'b1;
    end
    // A pin reset outside halt falls through and keeps both flags.
    if (rst || src_active) begin
      state_nxt = ST_HOLD;
      cnt_nxt = '0;
      if (rst) fast_nxt = startup_fast;
    end else begin
      unique case (state_r)
        ST_HOLD: begin
          state_nxt = ST_PWRUP;
          cnt_nxt = pwrup_cycles(pwrup_delay_sel) - CNT_W'(1);
        end
        ST_PWRUP: begin
          if (cnt_r == '0) begin
            state_nxt = ST_OST;
            cnt_nxt = CNT_W'(`OSC_STARTUP_CYC - 1);
          end else cnt_nxt = cnt_r - CNT_W'(1);
        end
        ST_OST: begin
          if (cnt_r == '0) state_nxt = ST_RUN;
          else cnt_nxt = cnt_r - CNT_W'(1);
        end
        ST_RUN: begin
          fast_nxt = fast_osc_select;
          if (halt_instruction ||
              (mode_write && operating_mode_field == `OPMODE_HALT))
            state_nxt = ST_HALT;
          else if (mode_write && operating_mode_field == `OPMODE_STANDBY)
            state_nxt = ST_STANDBY;
        end
        ST_STANDBY: begin
          if (timer0_overflow || timer1_underflow || wdt_s || chg_s ||
              int_s || low_voltage_detect)
            state_nxt = ST_RUN;
        end
        ST_HALT: begin
          if (wdt_s || chg_s || int_s) begin
            state_nxt = ST_WAKE;
            cnt_nxt = xtal_mode ? CNT_W'(`WAKE_XTAL_CYC - 1)
                                : CNT_W'(`WAKE_RC_CYC - 1);
          end
        end
        ST_WAKE: begin
          if (cnt_r == '0) state_nxt = ST_RUN;
          else cnt_nxt = cnt_r - CNT_W'(1);
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    state_r <= state_nxt;
    cnt_r <= cnt_nxt;
    to_r <= to_nxt;
    pd_r <= pd_nxt;
    fast_r <= fast_nxt;
  end

  // Gating outputs, each registered from the next-state view.
  logic run_n, stby_n, halt_n, seq_n;
  always_comb begin
    run_n = (state_nxt == ST_RUN);
    stby_n = (state_nxt == ST_STANDBY);
    halt_n = (state_nxt == ST_HALT) || (state_nxt == ST_WAKE);
    seq_n = (state_nxt == ST_HOLD) || (state_nxt == ST_PWRUP) ||
            (state_nxt == ST_OST);
  end

  always_ff @(posedge ref_clk) begin
    system_reset <= seq_n;
    timeout_flag_n <= to_nxt;
    powerdown_flag_n <= pd_nxt;
    cpu_run <= run_n;
    sys_clk_fast <= fast_nxt;
    // The fast oscillator runs during the wake count so it can settle.
    fast_osc_en <= seq_n || (state_nxt == ST_WAKE) ||
                   ((run_n || stby_n) && !(fast_osc_stop && !fast_nxt));
    slow_osc_en <= !(state_nxt == ST_HALT);
    timer0_run <= (run_n || stby_n) && timer0_enable;
    timer1_run <= (run_n || stby_n) && timer1_enable;
    periph_run <= (run_n || stby_n) && periph_enable;
    watchdog_run <= !seq_n && watchdog_option && watchdog_enable;
  end
endmodule // reset_and_power_mode_control

// [verilog/rst_pwr_cfg.svh]
`ifndef RST_PWR_CFG_SVH
`define RST_PWR_CFG_SVH

// Operating-mode field encodings.
`define OPMODE_RUN 2'h0
`define OPMODE_HALT 2'h1
`define OPMODE_STANDBY 2'h2

// Power-up delay figures in microseconds, one per configuration code.
`define PWRUP_US_0 140
`define PWRUP_US_1 4500
`define PWRUP_US_2 18000
`define PWRUP_US_3 72000
`define PWRUP_US_4 288000
`define CLK_MHZ 10

// Start-up and wake-up counts in oscillator cycles.
`define OSC_STARTUP_CYC 16
`define WAKE_XTAL_CYC 512
`define WAKE_RC_CYC 16

`endif

// [verilog/rst_pwr_pkg.sv]
package rst_pwr_pkg;
  typedef enum logic [2:0] {
    ST_HOLD,
    ST_PWRUP,
    ST_OST,
    ST_RUN,
    ST_STANDBY,
    ST_HALT,
    ST_WAKE
  } seq_state_e;
endpackage

// [verilog/sync2.sv]
module sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  input wire logic [WIDTH-1:0] reset_val,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] sync_nxt;

  always_comb begin
    meta_nxt = async_in;
    sync_nxt = meta_r;
    if (rst) begin
      meta_nxt = reset_val;
      sync_nxt = reset_val;
    end
  end

  always_ff @(posedge ref_clk) begin
    meta_r <= meta_nxt;
    sync_out <= sync_nxt;
  end
endmodule // sync2
